// [rtl/fpa_adder.sv]
// adder with carry-outs of the two top stages
`timescale 1ns/10ps
module fpa_adder
#(
  parameter int WIDTH = 32
)
(
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] b_in,
  input wire logic carry_in,
  output logic [WIDTH-1:0] sum,
  output logic carry_top,
  output logic carry_next
);

  // ==========================================================
  // elaboration check
  if (WIDTH < 2)
  begin : g_width_check
    $error("fpa_adder needs at least two bits");
  end

  // ==========================================================
  // low stages, then the top stage on its own
  logic [WIDTH-1:0] low;
  logic [1:0] top;

  // low part keeps its carry in the spare top bit
  assign low = {1'b0, a_in[WIDTH-2:0]} + {1'b0, b_in[WIDTH-2:0]} + {{(WIDTH-1){1'b0}}, carry_in};
  assign carry_next = low[WIDTH-1];
  assign top = {1'b0, a_in[WIDTH-1]} + {1'b0, b_in[WIDTH-1]} + {1'b0, carry_next};
  assign sum = {top[0], low[WIDTH-2:0]};
  assign carry_top = top[1];

endmodule

// [rtl/fpa_alu.sv]
// fixed-point alu with data registers and an axi4-lite register port
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
// Contract
// - unit field 00 runs the alu, 01 the multiplier, 10 the shifter.
// - add sums x and y sources into the destination register.
// - subtract writes x minus y into the destination.
// - every result write zeroes the destination's extension bits.
// - with saturation on, add/subtract clamp to largest positive or most negative.
// - zero flag follows an all-zero result; underflow, sign, invalid flags clear.
// - negative flag copies the result's top bit.
// - overflow flag is xor of the two top adder carries.
// - carry flag is the top adder carry.
// - add-with-carry adds x, y and the stored carry flag.
// - subtract-with-borrow gives x minus y plus carry minus one.
// - average halves x plus y, clears overflow, sets carry from the top adder carry.
// - average halving rounds to nearest or truncates by the rounding bit.
// - signed compare writes nothing, zero flag on equal, other five cleared.
// - compare sets negative flag when x is below y.
// - status bits 24 to 31 hold the last eight compare outcomes.
// - each compare shifts the history right, dropping bit 24.
// - status top bit is set after a compare when x exceeds y.
// - unsigned compare judges operands as magnitudes, same effects otherwise.
// - carry-add adds carry to x, saturating positive overflow only.
// - borrow-add adds carry minus one to x, saturating positive overflow.
// - increment adds one to x, saturating to largest positive.
// - decrement subtracts one from x, saturating to most negative.
module fpa_alu
  import fpa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire fpa_axil_req_type axi_req,
  output fpa_axil_rsp_type axi_rsp,
  output logic mult_issue,
  output logic shift_issue,
  output logic [FIELD_W-1:0] issue_field
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] mode;
    logic [DATA_W-1:0] status;
    logic [REG_COUNT-1:0][REG_W-1:0] regs;
    logic aw_held;
    logic [31:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    fpa_axil_rsp_type rsp;
    logic mult_issue;
    logic shift_issue;
    logic [FIELD_W-1:0] issue_field;
  } fpa_state_type;

  fpa_state_type q;
  fpa_state_type next_q;

  // ==========================================================
  // helpers

  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // true when a word address falls in the data register window
  function automatic logic in_regfile(input logic [31:0] addr);
    return (addr >= REGFILE_BASE) && (addr < REGFILE_BASE + REGFILE_SPAN);
  endfunction

  // ==========================================================
  // write decode
  logic wr_fire;
  logic [31:0] wr_addr;
  logic [31:0] field_word;
  logic [FIELD_W-1:0] field;
  logic [IDX_W-1:0] wr_idx;

  // a write runs once address and data are both held
  assign wr_fire = q.aw_held & q.w_held;
  assign wr_addr = {q.aw_addr[31:2], 2'b00};
  assign wr_idx = wr_addr[REG_SEL_LO +: IDX_W];
  assign field_word = merge_bytes(32'h00000000, q.w_data, q.w_strb);
  assign field = field_word[FIELD_W-1:0];

  // ==========================================================
  // compute field and operands
  logic [1:0] unit;
  logic [7:0] opc;
  logic [IDX_W-1:0] dst;
  logic [IDX_W-1:0] xsrc;
  logic [IDX_W-1:0] ysrc;
  logic [DATA_W-1:0] x_val;
  logic [DATA_W-1:0] y_val;
  logic carry_in;

  // fixed-point field sits above the extension bits
  assign unit = field[UNIT_LO +: 2];
  assign opc = field[OPC_LO +: 8];
  assign dst = field[DST_LO +: IDX_W];
  assign xsrc = field[XSRC_LO +: IDX_W];
  assign ysrc = field[YSRC_LO +: IDX_W];
  assign x_val = q.regs[xsrc][REG_W-1:EXT_W];
  assign y_val = q.regs[ysrc][REG_W-1:EXT_W];
  assign carry_in = q.status[CARRY_BIT];

  // ==========================================================
  // adder operand selection
  logic [DATA_W-1:0] add_b;
  logic add_cin;
  logic [DATA_W-1:0] add_sum;
  logic c_top;
  logic c_next;

  // subtraction runs as x plus inverted y
  always_comb
  begin
    add_b = y_val;
    add_cin = 1'b0;
    case (opc)
      OP_SUB:
      begin
        add_b = ~y_val;
        add_cin = 1'b1;
      end
      OP_ADDC:
      begin
        add_cin = carry_in;
      end
      OP_SUBB:
      begin
        add_b = ~y_val;
        add_cin = carry_in;
      end
      OP_ADDCI:
      begin
        add_b = '0;
        add_cin = carry_in;
      end
      OP_SUBBI:
      begin
        add_b = '1;
        add_cin = carry_in;
      end
      OP_INC:
      begin
        add_b = '0;
        add_cin = 1'b1;
      end
      OP_DEC:
      begin
        add_b = '1;
        add_cin = 1'b0;
      end
      default:
      begin
        add_b = y_val;
        add_cin = 1'b0;
      end
    endcase
  end

  fpa_adder #(
    .WIDTH(DATA_W)
  ) u_adder (
    .a_in(x_val),
    .b_in(add_b),
    .carry_in(add_cin),
    .sum(add_sum),
    .carry_top(c_top),
    .carry_next(c_next)
  );

  // ==========================================================
  // result, saturation and flags
  logic [DATA_W-1:0] res;
  logic [DATA_W-1:0] half;
  logic ovf;
  logic pos_ovf;
  logic neg_ovf;
  logic f_ovf;
  logic f_carry;
  logic f_zero;
  logic f_neg;
  logic is_cmp;
  logic known;
  logic eq;
  logic lt;
  logic sat;

  // overflow from the two top carries
  assign ovf = c_top ^ c_next;
  assign pos_ovf = ovf & add_sum[DATA_W-1];
  assign neg_ovf = ovf & ~add_sum[DATA_W-1];
  assign sat = q.mode[SAT_BIT];
  // true sign of the sum shifted into the top
  assign half = {add_sum[DATA_W-1] ^ ovf, add_sum[DATA_W-1:1]};
  assign eq = (x_val == y_val);

  always_comb
  begin
    res = add_sum;
    f_ovf = ovf;
    f_carry = c_top;
    is_cmp = 1'b0;
    known = 1'b1;
    lt = 1'b0;
    case (opc)
      OP_ADD, OP_SUB, OP_ADDC, OP_SUBB:
      begin
        if (sat && pos_ovf)
        begin
          res = MAX_POS;
        end
        else if (sat && neg_ovf)
        begin
          res = MIN_NEG;
        end
      end
      OP_ADDCI, OP_SUBBI, OP_INC:
      begin
        if (sat && pos_ovf)
        begin
          res = MAX_POS;
        end
      end
      OP_DEC:
      begin
        if (sat && neg_ovf)
        begin
          res = MIN_NEG;
        end
      end
      OP_AVG:
      begin
        // nearest rounds the tie to even
        res = half + {{(DATA_W-1){1'b0}}, q.mode[ROUND_BIT] & add_sum[0] & half[0]};
        f_ovf = 1'b0;
      end
      OP_CMP:
      begin
        is_cmp = 1'b1;
        lt = $signed(x_val) < $signed(y_val);
      end
      OP_CMPU:
      begin
        is_cmp = 1'b1;
        lt = x_val < y_val;
      end
      default:
      begin
        known = 1'b0;
      end
    endcase
    // compare reports no overflow or carry
    if (is_cmp)
    begin
      f_ovf = 1'b0;
      f_carry = 1'b0;
    end
    f_zero = is_cmp ? eq : (res == '0);
    f_neg = is_cmp ? lt : res[DATA_W-1];
  end

  // ==========================================================
  // read decode
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [IDX_W-1:0] rd_idx;

  assign rd_addr = {axi_req.araddr[31:2], 2'b00};
  assign rd_idx = rd_addr[REG_SEL_LO +: IDX_W];

  // unmapped reads return zero with slverr
  always_comb
  begin
    rd_ok = 1'b1;
    rd_data = 32'h00000000;
    if (rd_addr == MODE_OFFSET)
    begin
      rd_data = {30'h00000000, q.mode};
    end
    else if (rd_addr == STATUS_OFFSET)
    begin
      rd_data = q.status;
    end
    else if (rd_addr == COMPUTE_OFFSET)
    begin
      rd_data = {9'h000, q.issue_field};
    end
    else if (in_regfile(rd_addr))
    begin
      if (rd_addr[REG_EXT_BIT])
      begin
        rd_data = {24'h000000, q.regs[rd_idx][EXT_W-1:0]};
      end
      else
      begin
        rd_data = q.regs[rd_idx][REG_W-1:EXT_W];
      end
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_q = q;
    next_q.mult_issue = 1'b0;
    next_q.shift_issue = 1'b0;
    next_q.rsp.bvalid = q.rsp.bvalid & ~axi_req.bready;
    next_q.rsp.rvalid = q.rsp.rvalid & ~axi_req.rready;
    // address and data are taken in either order
    if (q.rsp.awready && axi_req.awvalid)
    begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = axi_req.awaddr;
    end
    if (q.rsp.wready && axi_req.wvalid)
    begin
      next_q.w_held = 1'b1;
      next_q.w_data = axi_req.wdata;
      next_q.w_strb = axi_req.wstrb;
    end
    if (wr_fire)
    begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.rsp.bvalid = 1'b1;
      next_q.rsp.bresp = RESP_OKAY;
      if (wr_addr == MODE_OFFSET)
      begin
        next_q.mode = field_word[1:0] | (q.mode & ~{q.w_strb[0], q.w_strb[0]});
      end
      else if (wr_addr == STATUS_OFFSET)
      begin
        next_q.status = merge_bytes(q.status, q.w_data, q.w_strb) & STATUS_MASK;
      end
      else if (wr_addr == COMPUTE_OFFSET)
      begin
        next_q.issue_field = field;
        if (unit == UNIT_MULT)
        begin
          next_q.mult_issue = 1'b1;
        end
        else if (unit == UNIT_SHIFT)
        begin
          next_q.shift_issue = 1'b1;
        end
        else if (unit == UNIT_ALU && known)
        begin
          if (!is_cmp)
          begin
            next_q.regs[dst] = {res, {EXT_W{1'b0}}};
          end
          // flags on the same edge as the result
          next_q.status[ZERO_BIT] = f_zero;
          next_q.status[NEG_BIT] = f_neg;
          next_q.status[OVF_BIT] = f_ovf;
          next_q.status[CARRY_BIT] = f_carry;
          next_q.status[UNDER_BIT] = 1'b0;
          next_q.status[SIGN_BIT] = 1'b0;
          next_q.status[INVALID_BIT] = 1'b0;
          if (is_cmp)
          begin
            next_q.status[HIST_LO +: HIST_W-1] = q.status[HIST_LO+1 +: HIST_W-1];
            next_q.status[DATA_W-1] = ~eq & ~lt;
          end
        end
      end
      else if (in_regfile(wr_addr))
      begin
        if (wr_addr[REG_EXT_BIT])
        begin
          next_q.regs[wr_idx][EXT_W-1:0] = field_word[EXT_W-1:0] |
            (q.regs[wr_idx][EXT_W-1:0] & ~{EXT_W{q.w_strb[0]}});
        end
        else
        begin
          next_q.regs[wr_idx][REG_W-1:EXT_W] = merge_bytes(q.regs[wr_idx][REG_W-1:EXT_W], q.w_data, q.w_strb);
        end
      end
      else
      begin
        next_q.rsp.bresp = RESP_SLVERR;
      end
    end
    // read answers one cycle after the address is taken
    if (q.rsp.arready && axi_req.arvalid)
    begin
      next_q.rsp.rvalid = 1'b1;
      next_q.rsp.rdata = rd_data;
      next_q.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    next_q.rsp.awready = ~next_q.aw_held & ~next_q.rsp.bvalid;
    next_q.rsp.wready = ~next_q.w_held & ~next_q.rsp.bvalid;
    next_q.rsp.arready = ~next_q.rsp.rvalid;
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.mode <= MODE_RESET;
      q.status <= STATUS_RESET;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign axi_rsp = q.rsp;
  assign mult_issue = q.mult_issue;
  assign shift_issue = q.shift_issue;
  assign issue_field = q.issue_field;

endmodule

// [rtl/fpa_pkg.sv]
// constants, field layout and bus carriers of the fixed-point alu
package fpa_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W = 32;
  localparam int EXT_W = 8;
  localparam int REG_W = DATA_W + EXT_W;
  localparam int REG_COUNT = 16;
  localparam int IDX_W = 4;
  localparam int FIELD_W = 23;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [31:0] MODE_OFFSET = 32'h00000000;
  localparam logic [31:0] STATUS_OFFSET = 32'h00000004;
  localparam logic [31:0] COMPUTE_OFFSET = 32'h00000008;
  localparam logic [31:0] REGFILE_BASE = 32'h00000080;
  localparam logic [31:0] REGFILE_SPAN = 32'h00000080;
  localparam int REG_SEL_LO = 3;
  localparam int REG_EXT_BIT = 2;

  // ==========================================================
  // mode control and status layout, reset values
  localparam int SAT_BIT = 0;
  localparam int ROUND_BIT = 1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam int ZERO_BIT = 0;
  localparam int OVF_BIT = 1;
  localparam int NEG_BIT = 2;
  localparam int CARRY_BIT = 3;
  localparam int SIGN_BIT = 4;
  localparam int INVALID_BIT = 5;
  localparam int UNDER_BIT = 6;
  localparam int HIST_LO = 24;
  localparam int HIST_W = 8;
  localparam logic [31:0] STATUS_MASK = 32'hff00007f;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;

  // ==========================================================
  // compute field layout and codes
  localparam int UNIT_LO = 20;
  localparam int OPC_LO = 12;
  localparam int DST_LO = 8;
  localparam int XSRC_LO = 4;
  localparam int YSRC_LO = 0;
  localparam logic [1:0] UNIT_ALU = 2'h0;
  localparam logic [1:0] UNIT_MULT = 2'h1;
  localparam logic [1:0] UNIT_SHIFT = 2'h2;
  localparam logic [7:0] OP_ADD = 8'h01;
  localparam logic [7:0] OP_SUB = 8'h02;
  localparam logic [7:0] OP_ADDC = 8'h05;
  localparam logic [7:0] OP_SUBB = 8'h06;
  localparam logic [7:0] OP_AVG = 8'h09;
  localparam logic [7:0] OP_CMP = 8'h0a;
  localparam logic [7:0] OP_CMPU = 8'h0b;
  localparam logic [7:0] OP_ADDCI = 8'h25;
  localparam logic [7:0] OP_SUBBI = 8'h26;
  localparam logic [7:0] OP_INC = 8'h29;
  localparam logic [7:0] OP_DEC = 8'h2a;
  localparam logic [31:0] MAX_POS = 32'h7fffffff;
  localparam logic [31:0] MIN_NEG = 32'h80000000;

  // ==========================================================
  // axi4-lite carriers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } fpa_axil_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fpa_axil_rsp_type;

endpackage

// [testbench/fixed_point_alu_arith_compare_tb.sv]
// self-checking bench for the fixed-point alu
`timescale 1ns/10ps
module fixed_point_alu_arith_compare_tb
  import fpa_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  fpa_axil_req_type axi_req;
  fpa_axil_rsp_type axi_rsp;
  logic mult_issue;
  logic shift_issue;
  logic [FIELD_W-1:0] issue_field;
  int n_errors = 0;
  int checks_done = 0;
  int n_mult = 0;
  int n_shift = 0;
  logic [31:0] mst = 32'h0;
  logic [7:0] ops [11] = '{OP_ADD, OP_SUB, OP_ADDC, OP_SUBB, OP_AVG, OP_CMP, OP_CMPU, OP_ADDCI, OP_SUBBI,
    OP_INC, OP_DEC};
  logic [31:0] vx [5] = '{32'h7fffffff, 32'h80000000, 32'h3, 32'h5, 32'hffffffff};
  logic [31:0] vy [5] = '{32'h1, 32'h1, 32'hfffffffd, 32'h5, 32'h1};

  // ==========================================================
  // clock, design and bus master
  always #50 aclk = ~aclk;
  fpa_alu i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .mult_issue(mult_issue), .shift_issue(shift_issue), .issue_field(issue_field));
  fpa_axil_host i_host (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));

  // count issue pulses
  always @(posedge aclk)
  begin
    if (mult_issue === 1'b1)
      n_mult++;
    if (shift_issue === 1'b1)
      n_shift++;
  end

  // ==========================================================
  // reference model: result and status after one operation
  function automatic void model(input logic [7:0] op, input logic [31:0] x, input logic [31:0] y,
    input logic [1:0] m, inout logic [31:0] r, inout logic [31:0] st);
    logic [31:0] b;
    logic ci;
    logic [32:0] s;
    logic [32:0] t;
    logic [31:0] lo;
    logic v;
    logic eq;
    logic lt;
    b = y;
    ci = st[CARRY_BIT];
    case (op)
      OP_SUB: {b, ci} = {~y, 1'b1};
      OP_SUBB: b = ~y;
      OP_ADDCI: b = 32'h0;
      OP_SUBBI: b = 32'hffffffff;
      OP_INC: {b, ci} = {32'h0, 1'b1};
      OP_DEC: {b, ci} = {32'hffffffff, 1'b0};
      OP_ADD, OP_AVG: ci = 1'b0;
      default: ;
    endcase
    s = {1'b0, x} + {1'b0, b} + 33'(ci);
    lo = {1'b0, x[30:0]} + {1'b0, b[30:0]} + 32'(ci);
    v = s[32] ^ lo[31];
    eq = (x == y);
    lt = (op == OP_CMP) ? ($signed(x) < $signed(y)) : (x < y);
    if (op == OP_CMP || op == OP_CMPU)
    begin
      st = {!eq && !lt, st[31:25], 17'h0, 3'h0, 1'b0, lt, 1'b0, eq};
      return;
    end
    r = s[31:0];
    if (op == OP_AVG)
    begin
      // true signed sum kept apart so the carry flag still comes from s
      t = {x[31], x} + {y[31], y};
      r = t[32:1];
      if (m[ROUND_BIT] && t[0] && r[0])
        r = r + 32'h1;
      v = 1'b0;
    end
    else if (m[SAT_BIT] && v)
    begin
      if (s[31] && op != OP_DEC)
        r = MAX_POS;
      else if (!s[31] && !(op inside {OP_ADDCI, OP_SUBBI, OP_INC}))
        r = MIN_NEG;
    end
    st = {st[31:24], 17'h0, 3'h0, s[32], r[31], v, r == 32'h0};
  endfunction

  // ==========================================================
  // compare and bus helpers
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_host.wr(a, d, r);
    chk_resp(r, RESP_OKAY);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk_resp(r, RESP_OKAY);
    chk_val(d, exp);
  endtask

  // load operands, run one operation, check result, extension and status
  task automatic run_op(input logic [7:0] op, input logic [31:0] x, input logic [31:0] y,
    input logic [1:0] m, input logic c);
    logic [31:0] r;
    r = 32'h5a5a5a5a;
    mst = {mst[31:24], 20'h0, c, 3'h0};
    wr(MODE_OFFSET, {30'h0, m});
    wr(STATUS_OFFSET, mst);
    wr(REGFILE_BASE + 32'h8, x);
    wr(REGFILE_BASE + 32'h10, y);
    wr(REGFILE_BASE + 32'h18, r);
    wr(REGFILE_BASE + 32'h1c, 32'ha5);
    wr(COMPUTE_OFFSET, {10'h0, UNIT_ALU, op, 12'h312});
    model(op, x, y, m, r, mst);
    rdc(REGFILE_BASE + 32'h18, r);
    rdc(REGFILE_BASE + 32'h1c, (op == OP_CMP || op == OP_CMPU) ? 32'ha5 : 32'h0);
    rdc(STATUS_OFFSET, mst);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(25636));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(MODE_OFFSET, 32'h0);
    rdc(STATUS_OFFSET, 32'h0);
    $display("test reset done");
    foreach (ops[i])
      for (int m = 0; m < 4; m++)
        for (int v = 0; v < 5; v++)
          run_op(ops[i], vx[v], vy[v], m[1:0], 1'((v + m) % 2));
    $display("test directed done");
    repeat (100)
      run_op(ops[$urandom % 11], $urandom, $urandom, 2'($urandom), 1'($urandom));
    $display("test random done");
    wr(REGFILE_BASE + 32'h18, 32'h5a5a5a5a);
    for (int u = 1; u < 4; u++)
      wr(COMPUTE_OFFSET, {10'h0, 2'(u), OP_ADD, 12'h312});
    repeat (2) @(posedge aclk);
    rdc(REGFILE_BASE + 32'h18, 32'h5a5a5a5a);
    chk_val({9'h0, issue_field}, {10'h0, 2'h3, OP_ADD, 12'h312});
    chk_val(32'(n_mult), 32'h1);
    chk_val(32'(n_shift), 32'h1);
    i_host.wr(32'h40, 32'h1, r);
    chk_resp(r, RESP_SLVERR);
    i_host.rd(32'h40, d, r);
    chk_resp(r, RESP_SLVERR);
    chk_val(d, 32'h0);
    $display("test units done");
    test_done;
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    test_done;
  end
endmodule

// [testbench/fpa_alu_properties.sv]
// port assertions for the fixed-point alu
`timescale 1ns/10ps
module fpa_alu_properties
  import fpa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire fpa_axil_req_type axi_req,
  input wire fpa_axil_rsp_type axi_rsp,
  input wire logic mult_issue,
  input wire logic shift_issue,
  input wire logic [FIELD_W-1:0] issue_field
);
  // ==========================================================
  // clocking
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // issue pulses
  a_mult_unit: assert property (mult_issue |-> issue_field[UNIT_LO+:2] == UNIT_MULT)
    else $error("multiplier issue with wrong unit code");
  a_shift_unit: assert property (shift_issue |-> issue_field[UNIT_LO+:2] == UNIT_SHIFT)
    else $error("shifter issue with wrong unit code");
  a_issue_single: assert property ((mult_issue || shift_issue) |=> !(mult_issue || shift_issue))
    else $error("issue pulse longer than one cycle");
  a_issue_on_resp: assert property ((mult_issue || shift_issue) |-> $rose(axi_rsp.bvalid))
    else $error("issue pulse not with write response");

  // ==========================================================
  // register port timing
  a_b_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |=> ##1 axi_rsp.bvalid)
    else $error("write response late");
  a_b_release: assert property (axi_rsp.bvalid && axi_req.bready
    |=> !axi_rsp.bvalid ##[0:1] (axi_rsp.awready && axi_rsp.wready))
    else $error("write channel not released");
  a_r_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read data not one cycle after address");
  a_slverr_data: assert property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR |-> axi_rsp.rdata == 32'h0)
    else $error("refused read returns data");
endmodule

bind fpa_alu fpa_alu_properties i_props (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .mult_issue(mult_issue), .shift_issue(shift_issue), .issue_field(issue_field));

// [testbench/fpa_axil_host.sv]
// axi4-lite master standing in for the decoder side
`timescale 1ns/10ps
module fpa_axil_host
  import fpa_pkg::*;
(
  input wire logic aclk,
  output fpa_axil_req_type axi_req,
  input wire fpa_axil_rsp_type axi_rsp
);
  // idle bus at time zero
  initial axi_req = '0;

  // one write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready)
      begin
        axi_req.awvalid <= 1'b0;
        axi_req.awaddr <= ~a; // released lines carry no stale value
      end
      if (axi_req.wvalid && axi_rsp.wready)
      begin
        axi_req.wvalid <= 1'b0;
        axi_req.wdata <= ~d;
      end
      if (axi_rsp.bvalid)
        break;
    end
    resp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask

  // one read
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (axi_req.arvalid && axi_rsp.arready)
      begin
        axi_req.arvalid <= 1'b0;
        axi_req.araddr <= ~a;
      end
      if (axi_rsp.rvalid)
        break;
    end
    d = axi_rsp.rdata;
    resp = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask
endmodule
